// ==== core/dpfd_snd_end.sv ====
// Sender end issuing data port messages
`timescale 1ns/1ps
`default_nettype none
`include "dpfd_map.svh"
module dpfd_snd_end (
  input wire logic clk_sys,
  input wire logic srst,
  dpfd_link_if.snd lnk,
  input wire logic cmd_valid,
  input wire dpfd_pkg::dpfd_cmd_e cmd_kind,
  input wire dpfd_pkg::dpfd_thr_t cmd_thread,
  input wire logic [1:0] cmd_port,
  input wire logic [4:0] cmd_type,
  input wire logic cmd_hdr,
  input wire logic [7:0] cmd_sti,
  input wire logic [15:0] cmd_sideband_scaled_offset_field,
  input wire logic [3:0] cmd_lod,
  input wire logic [2:0] cmd_flush,
  input wire logic [2:0] cmd_rpc,
  input wire logic [4:0] cmd_sro,
  input wire logic [5:0] cmd_width,
  input wire logic [5:0] cmd_xoff,
  input wire logic [5:0] cmd_base_lo,
  input wire logic [5:0] cmd_pitch_lo,
  input wire logic cmd_linear,
  input wire logic cmd_packed422,
  input wire logic [2:0] cmd_pix_bytes,
  output logic cmd_ready,
  output logic res_valid,
  output logic res_err,
  output logic [127:0] res_data
);
  import dpfd_pkg::*;

  dpfd_snd_state_s s_ff;
  dpfd_snd_state_s nxt_s;

  always_comb begin
    logic bad;
    logic [5:0] pmask;
    nxt_s = s_ff;
    nxt_s.req_valid = 1'b0;
    nxt_s.wb_read = 1'b0;
    nxt_s.res_valid = 1'b0;
    nxt_s.res_err = 1'b0;
    pmask = {3'h0, cmd_pix_bytes} - 6'h01;
    bad = 1'b0;
    if (cmd_port != `DPFD_PORT_NOIDX && cmd_sti >= `DPFD_STI_RSV_LO &&
        cmd_sti <= `DPFD_STI_RSV_HI && cmd_kind == CMD_ACCESS) begin
      bad = 1'b1;
    end
    if (cmd_kind == CMD_ACCESS && cmd_type == `DPFD_MT_MMB_READ) begin
      if ((cmd_base_lo & `DPFD_BASE_ALIGN_MASK) != 6'h00 ||
          (cmd_linear && (cmd_pitch_lo & `DPFD_PITCH_ALIGN_MASK) != 6'h00)) begin
        bad = 1'b1;
      end
      if (cmd_packed422 ? ((cmd_width[1:0] | cmd_xoff[1:0]) != 2'h0) :
          (((cmd_width | cmd_xoff) & pmask) != 6'h00)) begin
        bad = 1'b1;
      end
    end
    unique case (s_ff.st)
      SND_IDLE: begin
        nxt_s.cmd_ready = 1'b1;
        if (cmd_valid && s_ff.cmd_ready) begin
          nxt_s.kind = cmd_kind;
          nxt_s.thr = cmd_thread;
          nxt_s.port = cmd_port;
          nxt_s.mtype = cmd_type;
          nxt_s.hdr = cmd_hdr;
          nxt_s.sti = cmd_sti;
          nxt_s.exdesc = {cmd_sideband_scaled_offset_field, 16'h0000};
          nxt_s.detail_level = cmd_lod;
          nxt_s.flush = cmd_flush;
          nxt_s.rpc = cmd_rpc;
          nxt_s.sub_register_offset = cmd_sro;
          nxt_s.width = cmd_width;
          nxt_s.follow = 1'b0;
          unique case (cmd_kind)
            CMD_QUERY: begin
              nxt_s.mtype = `DPFD_MT_QUERY;
              nxt_s.hdr = 1'b0;
            end
            CMD_FENCE: nxt_s.mtype = `DPFD_MT_FENCE;
            default: ;
          endcase
          if (bad) begin
            nxt_s.res_err = 1'b1;
          end else if (cmd_kind == CMD_WBREAD) begin
            nxt_s.wb_read = 1'b1;
            nxt_s.cmd_ready = 1'b0;
            nxt_s.st = SND_WB_SETTLE;
          end else begin
            nxt_s.cmd_ready = 1'b0;
            nxt_s.st = SND_ISSUE;
          end
        end
      end
      SND_ISSUE: begin
        if (!lnk.dev_block[s_ff.thr]) begin
          nxt_s.req_valid = 1'b1;
          if (s_ff.follow) begin
            nxt_s.st = SND_WAIT_CMPL;
          end else if (s_ff.kind != CMD_ACCESS || s_ff.mtype == `DPFD_MT_MMB_READ) begin
            nxt_s.st = SND_WAIT_RSP;
          end else begin
            nxt_s.res_valid = 1'b1;
            nxt_s.cmd_ready = 1'b1;
            nxt_s.st = SND_IDLE;
          end
        end
      end
      SND_WAIT_RSP: begin
        if (lnk.rsp_valid && lnk.rsp_thread == s_ff.thr) begin
          nxt_s.res_data = lnk.rsp_data;
          if (s_ff.kind == CMD_FENCE && s_ff.flush != 3'h0) begin
            // Flush may outlast the fence
            nxt_s.follow = 1'b1;
            nxt_s.port = `DPFD_PORT_GLOBAL;
            nxt_s.mtype = `DPFD_MT_GREAD;
            nxt_s.sti = `DPFD_STI_FLAT;
            nxt_s.st = SND_ISSUE;
          end else begin
            nxt_s.res_valid = 1'b1;
            nxt_s.cmd_ready = 1'b1;
            nxt_s.st = SND_IDLE;
          end
        end
      end
      SND_WAIT_CMPL: begin
        if (lnk.cmpl_valid && lnk.cmpl_thread == s_ff.thr) begin
          nxt_s.res_valid = 1'b1;
          nxt_s.cmd_ready = 1'b1;
          nxt_s.st = SND_IDLE;
        end
      end
      SND_WB_SETTLE: nxt_s.st = SND_WB_WAIT;
      SND_WB_WAIT: begin
        if (!lnk.dev_block[s_ff.thr]) begin
          nxt_s.res_valid = 1'b1;
          nxt_s.cmd_ready = 1'b1;
          nxt_s.st = SND_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================
  // Outputs
  assign lnk.req_valid = s_ff.req_valid;
  assign lnk.req_thread = s_ff.thr;
  assign lnk.req_port = s_ff.port;
  assign lnk.req_type = s_ff.mtype;
  assign lnk.req_hdr = s_ff.hdr;
  assign lnk.req_sti = s_ff.sti;
  assign lnk.req_exdesc = s_ff.exdesc;
  assign lnk.req_lod = s_ff.detail_level;
  assign lnk.req_flush = s_ff.flush;
  assign lnk.req_rpc = s_ff.rpc;
  assign lnk.req_sro = s_ff.sub_register_offset;
  assign lnk.req_width = s_ff.width;
  assign lnk.wb_read = s_ff.wb_read;
  assign lnk.wb_thread = s_ff.thr;
  assign cmd_ready = s_ff.cmd_ready;
  assign res_valid = s_ff.res_valid;
  assign res_err = s_ff.res_err;
  assign res_data = s_ff.res_data;
endmodule : dpfd_snd_end
`default_nettype wire

// ==== core/dpfd_map.svh ====
// Constants of the data port fence and descriptor decode ends
`ifndef DPFD_MAP_SVH
`define DPFD_MAP_SVH
// ==========================================
// Special surface table index entries
`define DPFD_STI_FLAT 8'hFF
`define DPFD_STI_SLM 8'hFE
`define DPFD_STI_BINDLESS 8'hFC
`define DPFD_STI_RSV_LO 8'hF0
`define DPFD_STI_RSV_HI 8'hFB
// ==========================================
// Extended descriptor fields
`define DPFD_SIDEBAND_SCALED_OFFSET_FIELD_MSB 31
`define DPFD_SIDEBAND_SCALED_OFFSET_FIELD_LSB 16
`define DPFD_SSO_MSB 31
`define DPFD_SSO_LSB 6
// ==========================================
// Message types and ports
`define DPFD_MT_QUERY 5'h1D
`define DPFD_MT_FENCE 5'h07
`define DPFD_MT_MMB_READ 5'h04
`define DPFD_MT_GREAD 5'h01
`define DPFD_MT_WIDE_BIT 4
`define DPFD_PORT_NOIDX 2'h2
`define DPFD_PORT_GLOBAL 2'h1
// ==========================================
// Limits, alignment and reset values
`define DPFD_LOD_LIMIT 5'h0F
`define DPFD_BASE_ALIGN_MASK 6'h1F
`define DPFD_PITCH_ALIGN_MASK 6'h3F
`define DPFD_FLUSH_ALL 3'h7
`define DPFD_CNT_RST 4'h0
`endif

// ==== core/dpfd_pkg.sv ====
// Types shared by the data port fence and descriptor decode ends
package dpfd_pkg;
  typedef logic [1:0] dpfd_thr_t;
  typedef enum logic [2:0] {MDL_TABLE, MDL_FLAT32, MDL_FLAT64, MDL_SLM, MDL_BINDLESS,
    MDL_RSV} dpfd_model_e;
  typedef enum logic [1:0] {RSP_QUERY, RSP_FENCE, RSP_MERGED} dpfd_rsp_e;
  typedef enum logic [1:0] {CMD_ACCESS, CMD_QUERY, CMD_FENCE, CMD_WBREAD} dpfd_cmd_e;
  typedef enum logic [2:0] {SND_IDLE, SND_ISSUE, SND_WAIT_RSP, SND_WAIT_CMPL, SND_WB_SETTLE,
    SND_WB_WAIT} dpfd_snd_st_e;
  typedef struct packed {
    logic [7:0] fmt;
    logic [2:0] stype;
    logic [13:0] width;
    logic [13:0] height;
    logic [10:0] depth;
    logic [3:0] mip_level_count;
    logic [3:0] minimum_detail_level;
  } dpfd_surf_s;
  typedef struct packed {
    dpfd_surf_s [3:0] surf;
    logic [3:0][3:0] out_cnt;
    logic [3:0] fence_pend;
    logic [3:0] wb_wait;
    logic [3:0] block;
    logic rsp_valid;
    dpfd_thr_t rsp_thread;
    dpfd_rsp_e rsp_kind;
    logic [127:0] rsp_data;
    logic cmpl_valid;
    dpfd_thr_t cmpl_thread;
    logic mem_valid;
    dpfd_thr_t mem_thread;
    dpfd_model_e mem_model;
    logic [31:0] mem_addr;
    logic flush_valid;
    logic [2:0] flush_mask;
  } dpfd_dev_state_s;
  typedef struct packed {
    dpfd_snd_st_e st;
    dpfd_cmd_e kind;
    logic follow;
    logic req_valid;
    dpfd_thr_t thr;
    logic [1:0] port;
    logic [4:0] mtype;
    logic hdr;
    logic [7:0] sti;
    logic [31:0] exdesc;
    logic [3:0] detail_level;
    logic [2:0] flush;
    logic [2:0] rpc;
    logic [4:0] sub_register_offset;
    logic [5:0] width;
    logic wb_read;
    logic cmd_ready;
    logic res_valid;
    logic res_err;
    logic [127:0] res_data;
  } dpfd_snd_state_s;
endpackage : dpfd_pkg

// ==== core/dpfd_link_if.sv ====
// Message link between shader threads and the data port
`timescale 1ns/1ps
`default_nettype none
interface dpfd_link_if;
  import dpfd_pkg::*;
  logic req_valid;
  dpfd_thr_t req_thread;
  logic [1:0] req_port;
  logic [4:0] req_type;
  logic req_hdr;
  logic [7:0] req_sti;
  logic [31:0] req_exdesc;
  logic [3:0] req_lod;
  logic [2:0] req_flush;
  logic [2:0] req_rpc;
  logic [4:0] req_sro;
  logic [5:0] req_width;
  logic wb_read;
  dpfd_thr_t wb_thread;
  logic [3:0] dev_block;
  logic rsp_valid;
  dpfd_thr_t rsp_thread;
  dpfd_rsp_e rsp_kind;
  logic [127:0] rsp_data;
  logic cmpl_valid;
  dpfd_thr_t cmpl_thread;
  modport dev (
    input req_valid, req_thread, req_port, req_type, req_hdr, req_sti, req_exdesc,
    input req_lod, req_flush, req_rpc, req_sro, req_width, wb_read, wb_thread,
    output dev_block, rsp_valid, rsp_thread, rsp_kind, rsp_data, cmpl_valid, cmpl_thread
  );
  modport snd (
    output req_valid, req_thread, req_port, req_type, req_hdr, req_sti, req_exdesc,
    output req_lod, req_flush, req_rpc, req_sro, req_width, wb_read, wb_thread,
    input dev_block, rsp_valid, rsp_thread, rsp_kind, rsp_data, cmpl_valid, cmpl_thread
  );
endinterface : dpfd_link_if
`default_nettype wire

// ==== core/dpfd_dev_end.sv ====
// Data port end: descriptor decode, surface query and per-thread fence
`timescale 1ns/1ps
`default_nettype none
`include "dpfd_map.svh"
// Contract
// - Detail level valid: below count, sum below 15
// - Invalid detail level zeroes width height depth
// - Query returns format type width height depth
// - Query ignores mask, no coordinate bounds checks
// - Query has no header; decode without it
// - Base address 48 bits zero-extended to 64
// - Fence blocks thread until earlier messages done
// - Fence completion writes undefined writeback value
// - Writeback read stalls thread until observable
// - Flush in mixed partition flushes whole partition
// - Sender follows flushing fence with global read
// - Index 255 flat model, 254 shared memory
// - Index 252 bindless, surface from offset field
// - Indices 240 to 251 are reserved
// - Index-less port: header flag and offset choose
// - Scaled offset lives in extended bits 31:16
// - Decode fields by message type and port
// - Merged block: base 32B, linear pitch 64B
// - Merged block: pair or pixel-size alignment
// - Fence orders shared memory outside fault mode
// - Merged read placed by pitch and offset
module dpfd_dev_end (
  input wire logic clk_sys,
  input wire logic srst,
  dpfd_link_if.dev lnk,
  input wire logic ss_we,
  input wire logic [1:0] ss_idx,
  input wire dpfd_pkg::dpfd_surf_s ss_wdata,
  input wire logic [47:0] ibase,
  input wire logic part_mixed,
  input wire logic mem_done,
  input wire dpfd_pkg::dpfd_thr_t mem_done_thread,
  output logic mem_valid,
  output dpfd_pkg::dpfd_thr_t mem_thread,
  output dpfd_pkg::dpfd_model_e mem_model,
  output logic [31:0] mem_addr,
  output logic flush_valid,
  output logic [2:0] flush_mask
);
  import dpfd_pkg::*;

  // ==========================================
  // Decode helpers
  function automatic dpfd_model_e addr_model(input logic [1:0] port, input logic hdr,
      input logic [4:0] mtype, input logic [7:0] sti);
    dpfd_model_e m;
    m = MDL_TABLE;
    if (port == `DPFD_PORT_NOIDX) begin
      // Header flag picks the model
      m = hdr ? MDL_FLAT32 : MDL_SLM;
    end else if (sti == `DPFD_STI_FLAT) begin
      m = mtype[`DPFD_MT_WIDE_BIT] ? MDL_FLAT64 : MDL_FLAT32;
    end else if (sti == `DPFD_STI_SLM) begin
      m = MDL_SLM;
    end else if (sti == `DPFD_STI_BINDLESS) begin
      m = MDL_BINDLESS;
    end else if (sti >= `DPFD_STI_RSV_LO && sti <= `DPFD_STI_RSV_HI) begin
      // Reserved entries are dropped rather than guessed at
      m = MDL_RSV;
    end
    return m;
  endfunction : addr_model

  function automatic logic [7:0] row_stride(input logic [2:0] rpc, input logic [5:0] width);
    logic [7:0] unit;
    logic [7:0] w;
    unit = {3'h0, rpc, 2'h0};
    w = {2'h0, width};
    if (rpc == 3'h0) begin
      return w;
    end
    return ((w + unit - 8'h01) / unit) * unit;
  endfunction : row_stride

  // ==========================================
  // State
  dpfd_dev_state_s s_ff;
  dpfd_dev_state_s nxt_s;

  always_comb begin
    dpfd_model_e mdl;
    dpfd_surf_s sf;
    logic tk;
    logic lod_ok;
    logic [4:0] lod_sum;
    logic found;
    nxt_s = s_ff;
    mdl = addr_model(lnk.req_port, lnk.req_hdr, lnk.req_type, lnk.req_sti);
    sf = s_ff.surf[lnk.req_sti[1:0]];
    tk = lnk.req_valid && !s_ff.block[lnk.req_thread];
    lod_sum = {1'b0, sf.minimum_detail_level} + {1'b0, lnk.req_lod};
    lod_ok = (lnk.req_lod < sf.mip_level_count) && (lod_sum < `DPFD_LOD_LIMIT);
    found = 1'b0;
    nxt_s.rsp_valid = 1'b0;
    nxt_s.cmpl_valid = 1'b0;
    nxt_s.mem_valid = 1'b0;
    nxt_s.flush_valid = 1'b0;
    if (ss_we) begin
      nxt_s.surf[ss_idx] = ss_wdata;
    end
    // Memory completions; shared memory counts too
    if (mem_done && s_ff.out_cnt[mem_done_thread] != `DPFD_CNT_RST) begin
      nxt_s.out_cnt[mem_done_thread] = s_ff.out_cnt[mem_done_thread] - 4'h1;
      nxt_s.cmpl_valid = 1'b1;
      nxt_s.cmpl_thread = mem_done_thread;
    end
    if (tk) begin
      unique case (lnk.req_type)
        `DPFD_MT_QUERY: begin
          // Header and coordinates unused here
          nxt_s.rsp_valid = 1'b1;
          nxt_s.rsp_thread = lnk.req_thread;
          nxt_s.rsp_kind = RSP_QUERY;
          nxt_s.rsp_data = {sf.fmt, sf.stype,
            lod_ok ? sf.width : 14'h0000,
            lod_ok ? sf.height : 14'h0000,
            lod_ok ? sf.depth : 11'h000,
            14'h0000, 16'h0000, ibase};
        end
        `DPFD_MT_FENCE: begin
          nxt_s.fence_pend[lnk.req_thread] = 1'b1;
          if (lnk.req_flush != 3'h0) begin
            nxt_s.flush_valid = 1'b1;
            nxt_s.flush_mask = part_mixed ? `DPFD_FLUSH_ALL : lnk.req_flush;
          end
        end
        default: begin
          if (mdl != MDL_RSV) begin
            nxt_s.mem_valid = 1'b1;
            nxt_s.mem_thread = lnk.req_thread;
            nxt_s.mem_model = mdl;
            unique case (mdl)
              MDL_BINDLESS: nxt_s.mem_addr = {6'h00,
                lnk.req_exdesc[`DPFD_SSO_MSB:`DPFD_SSO_LSB]};
              MDL_FLAT32, MDL_SLM, MDL_FLAT64: nxt_s.mem_addr =
                (lnk.req_port == `DPFD_PORT_NOIDX) ? {16'h0000,
                lnk.req_exdesc[`DPFD_SIDEBAND_SCALED_OFFSET_FIELD_MSB:`DPFD_SIDEBAND_SCALED_OFFSET_FIELD_LSB]} : 32'h00000000;
              default: nxt_s.mem_addr = {24'h000000, lnk.req_sti};
            endcase
            nxt_s.out_cnt[lnk.req_thread] = nxt_s.out_cnt[lnk.req_thread] + 4'h1;
            if (lnk.req_type == `DPFD_MT_MMB_READ) begin
              // Rows one stride apart from the offset
              nxt_s.rsp_valid = 1'b1;
              nxt_s.rsp_thread = lnk.req_thread;
              nxt_s.rsp_kind = RSP_MERGED;
              nxt_s.rsp_data = {112'h0, 3'h0, lnk.req_sro,
                row_stride(lnk.req_rpc, lnk.req_width)};
            end
          end
        end
      endcase
    end
    // Fence done at zero outstanding; one answer a cycle
    for (int t = 0; t < 4; t++) begin
      if (!nxt_s.rsp_valid && !found && s_ff.fence_pend[t] &&
          s_ff.out_cnt[t] == `DPFD_CNT_RST) begin
        found = 1'b1;
        nxt_s.fence_pend[t] = 1'b0;
        nxt_s.rsp_valid = 1'b1;
        nxt_s.rsp_thread = dpfd_thr_t'(t);
        nxt_s.rsp_kind = RSP_FENCE;
        nxt_s.rsp_data = 128'h0;
      end
    end
    for (int t = 0; t < 4; t++) begin
      if (s_ff.out_cnt[t] == `DPFD_CNT_RST) begin
        nxt_s.wb_wait[t] = 1'b0;
      end
    end
    if (lnk.wb_read && s_ff.out_cnt[lnk.wb_thread] != `DPFD_CNT_RST) begin
      nxt_s.wb_wait[lnk.wb_thread] = 1'b1;
    end
    // Only the owning thread stalls; others keep issuing
    nxt_s.block = nxt_s.fence_pend | nxt_s.wb_wait;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================
  // Outputs
  assign lnk.dev_block = s_ff.block;
  assign lnk.rsp_valid = s_ff.rsp_valid;
  assign lnk.rsp_thread = s_ff.rsp_thread;
  assign lnk.rsp_kind = s_ff.rsp_kind;
  assign lnk.rsp_data = s_ff.rsp_data;
  assign lnk.cmpl_valid = s_ff.cmpl_valid;
  assign lnk.cmpl_thread = s_ff.cmpl_thread;
  assign mem_valid = s_ff.mem_valid;
  assign mem_thread = s_ff.mem_thread;
  assign mem_model = s_ff.mem_model;
  assign mem_addr = s_ff.mem_addr;
  assign flush_valid = s_ff.flush_valid;
  assign flush_mask = s_ff.flush_mask;
endmodule : dpfd_dev_end
`default_nettype wire

// ==== sim/dpfd_link_props.sv ====
// Concurrent checks on the link
`timescale 1ns/1ps
`default_nettype none
`include "dpfd_map.svh"
module dpfd_link_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  input wire dpfd_pkg::dpfd_thr_t req_thread,
  input wire logic [1:0] req_port,
  input wire logic [4:0] req_type,
  input wire logic req_hdr,
  input wire logic [7:0] req_sti,
  input wire logic [4:0] req_sro,
  input wire logic [3:0] dev_block,
  input wire logic rsp_valid,
  input wire dpfd_pkg::dpfd_thr_t rsp_thread,
  input wire dpfd_pkg::dpfd_rsp_e rsp_kind,
  input wire logic [127:0] rsp_data
);
  import dpfd_pkg::*;
  logic [3:0] blk_q;
  // ==========================================
  // Block one cycle back, to tie a fence answer to its wait
  always_ff @(posedge clk_sys) begin
    blk_q <= dev_block;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ==========================================
  // Message steps
  sequence fence_sent;
    req_valid && req_type == `DPFD_MT_FENCE && !dev_block[req_thread];
  endsequence
  sequence query_sent;
    req_valid && req_type == `DPFD_MT_QUERY && !dev_block[req_thread];
  endsequence
  sequence merge_sent;
    req_valid && req_type == `DPFD_MT_MMB_READ && !dev_block[req_thread];
  endsequence
  // ==========================================
  // Assertions
  fence_blocks_a: assert property (fence_sent |=> dev_block[$past(req_thread)])
    else $error("fence did not block its thread");
  fence_release_a: assert property (rsp_valid && rsp_kind == RSP_FENCE
    |-> blk_q[rsp_thread] && !dev_block[rsp_thread]) else $error("fence answer without wait");
  no_blocked_send_a: assert property (req_valid |-> !dev_block[req_thread])
    else $error("blocked thread sent");
  query_answer_a: assert property (query_sent |=> rsp_valid && rsp_kind == RSP_QUERY
    && rsp_thread == $past(req_thread)) else $error("query answer missing");
  base_extend_a: assert property (rsp_valid && rsp_kind == RSP_QUERY
    |-> rsp_data[77:48] == 30'h0) else $error("base address not zero extended");
  query_no_hdr_a: assert property (req_valid && req_type == `DPFD_MT_QUERY |-> !req_hdr)
    else $error("query sent with header");
  rsv_index_a: assert property (req_valid && req_port != `DPFD_PORT_NOIDX
    && req_type != `DPFD_MT_FENCE |-> !(req_sti inside {[`DPFD_STI_RSV_LO:`DPFD_STI_RSV_HI]}))
    else $error("reserved index sent");
  merge_layout_a: assert property (merge_sent |=> rsp_valid && rsp_kind == RSP_MERGED
    && rsp_data[12:8] == $past(req_sro) && rsp_data[127:13] == 115'h0)
    else $error("merged read layout wrong");
endmodule : dpfd_link_props
`default_nettype wire

// ==== sim/dpfd_tb.sv ====
// Self-checking bench for both link ends
`timescale 1ns/1ps
`default_nettype none
`include "dpfd_map.svh"
module dpfd_tb;
  import dpfd_pkg::*;
  logic clk_sys, srst, cmd_valid, cmd_hdr, cmd_linear, cmd_packed422, cmd_ready, res_valid;
  logic res_err, ss_we, part_mixed, mem_done, mem_valid, flush_valid, got_err;
  dpfd_cmd_e cmd_kind;
  dpfd_thr_t cmd_thread, mem_done_thread, mem_thread;
  dpfd_model_e mem_model, last_model;
  dpfd_surf_s ss_wdata, e;
  dpfd_surf_s sf [4];
  logic [1:0] cmd_port, ss_idx;
  logic [4:0] cmd_type, cmd_sro;
  logic [7:0] cmd_sti;
  logic [15:0] cmd_sideband_scaled_offset_field;
  logic [3:0] cmd_lod, seen;
  logic [2:0] cmd_flush, cmd_rpc, cmd_pix_bytes, flush_mask, last_flush;
  logic [5:0] cmd_width, cmd_xoff, cmd_base_lo, cmd_pitch_lo;
  logic [127:0] res_data, got_data;
  logic [47:0] ibase;
  logic [31:0] mem_addr, last_addr;
  int error_cnt, tests_run, dly, i;
  dpfd_link_if lnk ();
  dpfd_dev_end u_dpfd_dev_end (.clk_sys(clk_sys), .srst(srst), .lnk(lnk.dev), .ss_we(ss_we),
    .ss_idx(ss_idx), .ss_wdata(ss_wdata), .ibase(ibase), .part_mixed(part_mixed),
    .mem_done(mem_done), .mem_done_thread(mem_done_thread), .mem_valid(mem_valid),
    .mem_thread(mem_thread), .mem_model(mem_model), .mem_addr(mem_addr),
    .flush_valid(flush_valid), .flush_mask(flush_mask));
  dpfd_snd_end u_dpfd_snd_end (.clk_sys(clk_sys), .srst(srst), .lnk(lnk.snd),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_thread(cmd_thread), .cmd_port(cmd_port),
    .cmd_type(cmd_type), .cmd_hdr(cmd_hdr), .cmd_sti(cmd_sti), .cmd_sideband_scaled_offset_field(cmd_sideband_scaled_offset_field),
    .cmd_lod(cmd_lod), .cmd_flush(cmd_flush), .cmd_rpc(cmd_rpc), .cmd_sro(cmd_sro),
    .cmd_width(cmd_width), .cmd_xoff(cmd_xoff), .cmd_base_lo(cmd_base_lo),
    .cmd_pitch_lo(cmd_pitch_lo), .cmd_linear(cmd_linear), .cmd_packed422(cmd_packed422),
    .cmd_pix_bytes(cmd_pix_bytes), .cmd_ready(cmd_ready), .res_valid(res_valid),
    .res_err(res_err), .res_data(res_data));
  dpfd_link_props u_dpfd_link_props (.clk_sys(clk_sys), .srst(srst), .req_valid(lnk.req_valid),
    .req_thread(lnk.req_thread), .req_port(lnk.req_port), .req_type(lnk.req_type),
    .req_hdr(lnk.req_hdr), .req_sti(lnk.req_sti), .req_sro(lnk.req_sro),
    .dev_block(lnk.dev_block), .rsp_valid(lnk.rsp_valid), .rsp_thread(lnk.rsp_thread),
    .rsp_kind(lnk.rsp_kind), .rsp_data(lnk.rsp_data));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Memory side: the latest access retires 20 cycles later
  always @(posedge clk_sys) begin
    mem_done <= 1'b0;
    if (dly > 0) begin
      dly <= dly - 1;
      mem_done <= (dly == 1);
    end
    if (mem_valid === 1'b1) begin
      dly <= 20;
      mem_done_thread <= mem_thread;
      last_model <= mem_model;
      last_addr <= mem_addr;
    end
    if (flush_valid === 1'b1) begin
      last_flush <= flush_mask;
    end
    seen <= seen | lnk.dev_block;
  end
  // ==========================================
  // Tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_mdl(input dpfd_model_e got, input dpfd_model_e exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mdl
  task automatic put_surf(input logic [1:0] idx, input dpfd_surf_s s);
    sf[idx] = s;
    @(posedge clk_sys);
    ss_we <= 1'b1;
    ss_idx <= idx;
    ss_wdata <= s;
    @(posedge clk_sys);
    ss_we <= 1'b0;
  endtask : put_surf
  // One command, then its answer or refusal
  task automatic issue(input dpfd_cmd_e k, input dpfd_thr_t t, input logic [1:0] p,
      input logic [4:0] ty, input logic h, input logic [7:0] s, input logic [15:0] sb);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_thread <= t;
    cmd_port <= p;
    cmd_type <= ty;
    cmd_hdr <= h;
    cmd_sti <= s;
    cmd_sideband_scaled_offset_field <= sb;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    while (res_valid !== 1'b1 && res_err !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    got_err = res_err;
    got_data = res_data;
    if (n >= 600) begin
      error_cnt++;
      $display("timeout at %0t", $time);
      close_out();
    end
  endtask : issue
  // ==========================================
  // Test tables
  logic [7:0] q_sti [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
  logic [3:0] q_lod [4] = '{4'h3, 4'h4, 4'h2, 4'h3};
  logic q_ok [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [1:0] d_port [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2};
  logic [4:0] d_type [7] = '{5'h01, 5'h11, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01};
  logic d_hdr [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] d_sti [7] = '{8'hFF, 8'hFF, 8'hFE, 8'hFC, 8'h03, 8'h00, 8'h00};
  dpfd_model_e d_mdl [7] = '{MDL_FLAT32, MDL_FLAT64, MDL_SLM, MDL_BINDLESS, MDL_TABLE,
    MDL_FLAT32, MDL_SLM};
  logic [5:0] m_base [7] = '{6'h00, 6'h10, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00};
  logic [5:0] m_pitch [7] = '{6'h00, 6'h00, 6'h20, 6'h00, 6'h00, 6'h00, 6'h20};
  logic [5:0] m_xoff [7] = '{6'h00, 6'h00, 6'h00, 6'h02, 6'h02, 6'h04, 6'h00};
  logic m_422 [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic m_lin [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic m_err [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  // ==========================================
  // Main sequence
  initial begin
    {cmd_valid, cmd_hdr, cmd_linear, cmd_packed422, ss_we, part_mixed} = 6'h00;
    {cmd_thread, cmd_port, ss_idx, cmd_type, cmd_sro, cmd_sti, cmd_sideband_scaled_offset_field} = 40'h0;
    {cmd_lod, cmd_flush, cmd_rpc, cmd_pix_bytes, cmd_width, cmd_xoff} = 25'h0;
    {cmd_base_lo, cmd_pitch_lo, seen, last_flush, last_addr} = 51'h0;
    cmd_kind = CMD_ACCESS;
    last_model = MDL_RSV;
    ss_wdata = '0;
    ibase = 48'h1234_5678_9ABC;
    srst = 1'b1;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    put_surf(2'h1, {8'h2A, 3'h1, 14'h0100, 14'h0080, 11'h004, 4'h4, 4'h2});
    put_surf(2'h2, {8'h3C, 3'h2, 14'h0040, 14'h0020, 11'h001, 4'hF, 4'hC});
    for (i = 0; i < 4; i++) begin
      cmd_lod <= q_lod[i];
      issue(CMD_QUERY, 2'h0, 2'h0, `DPFD_MT_QUERY, 1'b1, q_sti[i], 16'h0);
      e = sf[i / 2 + 1];
      chk(got_data, {e.fmt, e.stype, q_ok[i] ? e.width : 14'h0, q_ok[i] ? e.height : 14'h0,
        q_ok[i] ? e.depth : 11'h0, 30'h0, ibase});
    end
    $display("test surface query done");
    for (i = 0; i < 7; i++) begin
      issue(CMD_ACCESS, 2'h0, d_port[i], d_type[i], d_hdr[i], d_sti[i], 16'h1234 + 16'(i));
      repeat (2) @(posedge clk_sys);
      #1;
      chk_mdl(last_model, d_mdl[i]);
      if (d_port[i] == 2'h2 || d_sti[i] == 8'hFF) begin
        chk(128'(last_addr), 128'(d_port[i] == 2'h2 ? 32'h1234 + 32'(i) : 32'h0));
      end
    end
    for (i = 240; i < 252; i++) begin
      issue(CMD_ACCESS, 2'h0, 2'h0, `DPFD_MT_GREAD, 1'b0, 8'(i), 16'h0);
      chk(128'(got_err), 128'h1);
    end
    $display("test descriptor decode done");
    cmd_rpc <= 3'h2;
    cmd_sro <= 5'h04;
    cmd_width <= 6'd12;
    cmd_pix_bytes <= 3'h4;
    for (i = 0; i < 7; i++) begin
      cmd_base_lo <= m_base[i];
      cmd_pitch_lo <= m_pitch[i];
      cmd_xoff <= m_xoff[i];
      cmd_packed422 <= m_422[i];
      cmd_linear <= m_lin[i];
      issue(CMD_ACCESS, 2'h3, 2'h0, `DPFD_MT_MMB_READ, 1'b0, 8'h03, 16'h0);
      chk(128'(got_err), 128'(m_err[i]));
      if (!m_err[i]) begin
        chk(got_data, {112'h0, 3'h0, 5'h04, 8'h10});
      end
    end
    $display("test merged read done");
    cmd_flush <= 3'h1;
    seen = 4'h0;
    issue(CMD_ACCESS, 2'h1, 2'h0, `DPFD_MT_GREAD, 1'b0, 8'h03, 16'h0);
    issue(CMD_FENCE, 2'h1, 2'h0, `DPFD_MT_FENCE, 1'b0, 8'h00, 16'h0);
    chk(128'(seen[1]), 128'h1);
    chk(128'(seen[0]), 128'h0);
    chk(128'(last_flush), 128'h1);
    chk_mdl(last_model, MDL_FLAT32);
    part_mixed <= 1'b1;
    seen = 4'h0;
    issue(CMD_ACCESS, 2'h1, 2'h0, `DPFD_MT_GREAD, 1'b0, 8'hFE, 16'h0);
    issue(CMD_FENCE, 2'h1, 2'h0, `DPFD_MT_FENCE, 1'b0, 8'h00, 16'h0);
    chk(128'(seen[1]), 128'h1);
    chk(128'(last_flush), 128'h7);
    chk(128'(got_err), 128'h0);
    seen = 4'h0;
    issue(CMD_ACCESS, 2'h2, 2'h0, `DPFD_MT_GREAD, 1'b0, 8'h03, 16'h0);
    issue(CMD_WBREAD, 2'h2, 2'h0, `DPFD_MT_FENCE, 1'b0, 8'h00, 16'h0);
    chk(128'(seen[2]), 128'h1);
    $display("test fence done");
    close_out();
  end
endmodule : dpfd_tb
`default_nettype wire
